/* File: ptcp_axil.v */
// ptcp_axil: AXI4-Lite slave front end, one write and one read at a time
// assumes the parent decodes wr_addr/s_axi_araddr combinationally
`timescale 1ns/100ps
`include "ptcp_consts.vh"
module ptcp_axil (
	input wire aclk,
	input wire aresetn,
	input wire [4:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [4:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output wire wr_en,
	output reg [4:0] wr_addr,
	output reg [31:0] wr_data,
	output reg [3:0] wr_strb,
	input wire wr_err,
	input wire [31:0] rd_data,
	input wire rd_err
);
	reg aw_held_r;
	reg w_held_r;

	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready = !w_held_r && !s_axi_bvalid;
	assign wr_en = aw_held_r && w_held_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// write side: address and data may arrive in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			wr_addr <= 5'h00;
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PTCP_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				wr_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end
			if (wr_en) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_err ? `PTCP_RESP_SLVERR : `PTCP_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read side: data captured on the address handshake
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `PTCP_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_err ? `PTCP_RESP_SLVERR : `PTCP_RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

/* File: ptcp_consts.vh */
// constants for the pulse-train command profiler
// assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus
`ifndef PTCP_CONSTS_VH
`define PTCP_CONSTS_VH

// register byte offsets
`define PTCP_OFS_PERIOD 5'h00
`define PTCP_OFS_CONTROL 5'h04
`define PTCP_OFS_STATE 5'h08
`define PTCP_OFS_COUNT 5'h0C
`define PTCP_OFS_WIDTH 5'h10
`define PTCP_OFS_ACCEPTS 5'h14

// command word fields
`define PTCP_PER_HI 27
`define PTCP_NEW_BIT 28
`define PTCP_DIR_HI 27
`define PTCP_DIR_LO 24
`define PTCP_ACC_HI 23
`define PTCP_ACC_LO 22
`define PTCP_CNT_HI 19
`define PTCP_DIR_FWD 4'h1
`define PTCP_DIR_REV 4'hF
`define PTCP_DIR_DLY 4'h0
`define PTCP_ACC_DEC 2'h3
`define PTCP_ACC_ACC 2'h2
`define PTCP_ACC_CST 2'h0

// state codes seen by software
`define PTCP_CODE_RESET 32'h00000000
`define PTCP_CODE_IDLE 32'h40000000
`define PTCP_CODE_ACTIVE 32'h80000000

// profile arithmetic
`define PTCP_DEN_FIRST 24'h000005
`define PTCP_DEN_STEP 24'h000004
`define PTCP_DEN_MIN 24'h000001
`define PTCP_WIDTH_MIN 28'h0000040
`define PTCP_DIV_STEPS 6'h20

// bus answers
`define PTCP_RESP_OKAY 2'h0
`define PTCP_RESP_SLVERR 2'h2

`endif

/* File: ptcp_divider.v */
// ptcp_divider: sequential restoring divider, one quotient bit per clock
// assumes start is only raised while the divider is not busy
`timescale 1ns/100ps
`include "ptcp_consts.vh"
module ptcp_divider (
	input wire aclk,
	input wire aresetn,
	input wire start,
	input wire [31:0] num,
	input wire [23:0] den,
	output reg done,
	output reg [31:0] quo
);
	reg busy_r;
	reg [5:0] cnt_r;
	reg [24:0] rem_r;
	reg [23:0] den_r;
	wire [24:0] trial = {rem_r[23:0], quo[31]};
	wire fits = trial >= {1'b0, den_r};

	// shift-subtract loop; 32 cycles trades speed for a tiny footprint
	always @(posedge aclk) begin
		if (!aresetn) begin
			busy_r <= 1'b0;
			done <= 1'b0;
			cnt_r <= 6'h00;
			rem_r <= 25'h0000000;
			den_r <= 24'h000000;
			quo <= 32'h00000000;
		end else begin
			done <= 1'b0;
			if (start && !busy_r) begin
				busy_r <= 1'b1;
				quo <= num;
				rem_r <= 25'h0000000;
				den_r <= den;
				cnt_r <= `PTCP_DIV_STEPS;
			end else if (busy_r) begin
				rem_r <= fits ? (trial - {1'b0, den_r}) : trial;
				quo <= {quo[30:0], fits};
				cnt_r <= cnt_r - 6'h01;
				if (cnt_r == 6'h01) begin
					busy_r <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule

/* File: ptcp_host_model.sv */
// host model: bus master that writes command words and reads registers
// assumes the bench calls wr and rd one at a time, right after an edge
`timescale 1ns/100ps
module ptcp_host_model (
	input wire aclk,
	output reg [4:0] s_axi_awaddr,
	output reg s_axi_awvalid,
	input wire s_axi_awready,
	output reg [31:0] s_axi_wdata,
	output reg [3:0] s_axi_wstrb,
	output reg s_axi_wvalid,
	input wire s_axi_wready,
	output reg s_axi_bready,
	input wire s_axi_bvalid,
	output reg [4:0] s_axi_araddr,
	output reg s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	output reg s_axi_rready,
	output reg hung
);
	integer slow;

	// idle bus at time zero
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = 0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, hung} = 0;
		s_axi_wstrb = 4'hF;
		slow = 0;
	end

	// released payload is inverted so a stale value cannot look valid
	task wr(input [4:0] a, input [31:0] d);
		integer i;
		reg aw, w, b;
		begin
			aw = 1'b1;
			w = 1'b1;
			b = 1'b0;
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= (slow == 0);
			for (i = 0; i < 200 && !b; i++) begin
				@(posedge aclk);
				if (aw && s_axi_awready) begin
					aw = 1'b0;
					s_axi_awvalid <= 1'b0;
					s_axi_awaddr <= ~a;
				end
				if (w && s_axi_wready) begin
					w = 1'b0;
					s_axi_wvalid <= 1'b0;
					s_axi_wdata <= ~d;
				end
				if (s_axi_bvalid && s_axi_bready) begin
					b = 1'b1;
					s_axi_bready <= 1'b0;
				end else if (i + 1 >= slow) s_axi_bready <= 1'b1;
			end
			// one more edge, so a following call never re-drives bready in this step
			@(posedge aclk);
			if (!b) hung <= 1'b1;
		end
	endtask

	// slow mode holds rready back to stretch the answer
	task rd(input [4:0] a, output [31:0] dout);
		integer i;
		reg ar, r;
		begin
			ar = 1'b1;
			r = 1'b0;
			dout = 32'h0;
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= (slow == 0);
			for (i = 0; i < 200 && !r; i++) begin
				@(posedge aclk);
				if (ar && s_axi_arready) begin
					ar = 1'b0;
					s_axi_arvalid <= 1'b0;
					s_axi_araddr <= ~a;
				end
				if (s_axi_rvalid && s_axi_rready) begin
					r = 1'b1;
					dout = s_axi_rdata;
					s_axi_rready <= 1'b0;
				end else if (i + 1 >= slow) s_axi_rready <= 1'b1;
			end
			// one more edge, so a following call never re-drives rready in this step
			@(posedge aclk);
			if (!r) hung <= 1'b1;
		end
	endtask
endmodule

/* File: ptcp_profiler.v */
// ptcp_profiler: command intake, step timing and speed-profile seeding
// assumes one 100 MHz clock; software writes commands over AXI4-Lite
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
`include "ptcp_consts.vh"
// Function
// - accel: width minus 2w over 4n+1
// - decel: divisor uses remaining steps, 4(m-n)-1
// - dividend 4w, quotient rounded by add-one-halve
// - accel divisor starts 5, then plus 4
// - decel divisor starts 4m-5, then minus 4
// - word one: reserved top nibble, period below
// - word two: new flag, direction, reserved bits
// - examine buffer only after steps exhausted
// - load width, keep private copy of control
// - no new command means enter idle
// - accepting command zeroes the control word
// - step count bits 19..0 load counter
// - decode decel, accel, constant; seed each
// - after seeding, first step starts at once
// - acceptance may raise a DMA request; here it only pulses command_accept for one cycle
// - start in reset, outputs low, await code
// - idle holds both outputs at last level
// - idle and active switch on their own
module ptcp_profiler (
	input wire aclk,
	input wire aresetn,
	input wire [4:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [4:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	output reg step_output_a,
	output reg step_output_b,
	output reg command_accept
);
	localparam ST_RESET = 3'h0;
	localparam ST_IDLE = 3'h1;
	localparam ST_CHECK = 3'h2;
	localparam ST_SEED = 3'h3;
	localparam ST_STEP = 3'h4;
	localparam ST_CALC = 3'h5;

	wire wr_en;
	wire [4:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	reg wr_err;
	reg [31:0] rd_data;
	reg rd_err;
	wire div_done;
	wire [31:0] div_quo;

	reg [2:0] state_r;
	reg [31:0] command_period_word_r;
	reg [31:0] command_control_word_r;
	reg [31:0] ctl_copy_r;
	reg [19:0] remaining_step_counter_r;
	reg [27:0] next_width_slot_r;
	reg [27:0] timer_r;
	reg [23:0] den_r;
	reg [31:0] accepts_r;
	reg div_start_r;

	wire [3:0] dir = ctl_copy_r[`PTCP_DIR_HI:`PTCP_DIR_LO];
	wire [1:0] acc = ctl_copy_r[`PTCP_ACC_HI:`PTCP_ACC_LO];
	wire moving = (dir == `PTCP_DIR_FWD) || (dir == `PTCP_DIR_REV);
	wire new_command_check = command_control_word_r[`PTCP_NEW_BIT];
	wire [27:0] half_width = {1'b0, next_width_slot_r[27:1]};
	wire [21:0] den_m4 = {remaining_step_counter_r, 2'b00};
	wire [27:0] load_width = command_period_word_r[`PTCP_PER_HI:0];

	// rounded width change: (4w / D + 1) / 2
	wire [32:0] quo_inc = {1'b0, div_quo} + 33'h000000001;
	wire [31:0] delta = quo_inc[32:1];
	wire [28:0] w_minus = {1'b0, next_width_slot_r} - {1'b0, delta[27:0]};
	wire [28:0] w_plus = {1'b0, next_width_slot_r} + {1'b0, delta[27:0]};
	wire big_delta = |delta[31:28];

	// byte-lane merge for software writes
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (strb[k]) begin
					merge[k*8 +: 8] = nw[k*8 +: 8];
				end
			end
		end
	endfunction

	wire [31:0] wr_merged_period = merge(command_period_word_r, wr_data, wr_strb);
	wire [31:0] wr_merged_ctl = merge(command_control_word_r, wr_data, wr_strb);
	wire wr_period = wr_en && (wr_addr == `PTCP_OFS_PERIOD);
	wire wr_ctl = wr_en && (wr_addr == `PTCP_OFS_CONTROL);
	wire wr_state = wr_en && (wr_addr == `PTCP_OFS_STATE);

	ptcp_axil u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	ptcp_divider u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(div_start_r),
		.num({2'b00, next_width_slot_r, 2'b00}),
		.den(den_r),
		.done(div_done),
		.quo(div_quo)
	);

	// write decode: count, width and accepts are read-only
	always @* begin
		case (wr_addr)
			`PTCP_OFS_PERIOD: wr_err = 1'b0;
			`PTCP_OFS_CONTROL: wr_err = 1'b0;
			`PTCP_OFS_STATE: wr_err = 1'b0;
			default: wr_err = 1'b1;
		endcase
	end

	// read decode; state code mirrors reset, idle or active
	always @* begin
		rd_err = 1'b0;
		case (s_axi_araddr)
			`PTCP_OFS_PERIOD: rd_data = command_period_word_r;
			`PTCP_OFS_CONTROL: rd_data = command_control_word_r;
			`PTCP_OFS_STATE: begin
				if (state_r == ST_RESET) begin
					rd_data = `PTCP_CODE_RESET;
				end else if (state_r == ST_IDLE ||
					(state_r == ST_CHECK && !new_command_check)) begin
					rd_data = `PTCP_CODE_IDLE;
				end else begin
					rd_data = `PTCP_CODE_ACTIVE;
				end
			end
			`PTCP_OFS_COUNT: rd_data = {12'h000, remaining_step_counter_r};
			`PTCP_OFS_WIDTH: rd_data = {4'h0, next_width_slot_r};
			`PTCP_OFS_ACCEPTS: rd_data = accepts_r;
			default: begin
				rd_data = 32'h00000000;
				rd_err = 1'b1;
			end
		endcase
	end

	// command buffer; a host write in the clearing cycle survives
	always @(posedge aclk) begin
		if (!aresetn) begin
			command_period_word_r <= 32'h00000000;
			command_control_word_r <= 32'h00000000;
		end else begin
			if (wr_period) begin
				command_period_word_r <= wr_merged_period;
			end
			if (wr_ctl) begin
				command_control_word_r <= wr_merged_ctl;
			end else if (state_r == ST_CHECK && new_command_check) begin
				command_control_word_r <= 32'h00000000;
			end
		end
	end

	// sequencer: intake, seeding, step timing and width update
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ST_RESET;
			ctl_copy_r <= 32'h00000000;
			remaining_step_counter_r <= 20'h00000;
			next_width_slot_r <= `PTCP_WIDTH_MIN;
			timer_r <= 28'h0000000;
			den_r <= `PTCP_DEN_MIN;
			accepts_r <= 32'h00000000;
			div_start_r <= 1'b0;
			command_accept <= 1'b0;
			step_output_a <= 1'b0;
			step_output_b <= 1'b0;
		end else begin
			div_start_r <= 1'b0;
			command_accept <= 1'b0;
			case (state_r)
				ST_RESET: begin
					step_output_a <= 1'b0;
					step_output_b <= 1'b0;
					if (wr_state && wr_data == `PTCP_CODE_IDLE) begin
						state_r <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					// outputs keep their last level while idle
					state_r <= ST_CHECK;
				end
				ST_CHECK: begin
					if (new_command_check) begin
						// latch word one and a private copy of word two
						next_width_slot_r <= (load_width < `PTCP_WIDTH_MIN) ?
							`PTCP_WIDTH_MIN : load_width;
						ctl_copy_r <= command_control_word_r;
						remaining_step_counter_r <=
							command_control_word_r[`PTCP_CNT_HI:0];
						accepts_r <= accepts_r + 32'h00000001;
						command_accept <= 1'b1;
						state_r <= ST_SEED;
					end else begin
						state_r <= ST_IDLE;
					end
				end
				ST_SEED: begin
					// seed divisor per acceleration type
					if (acc == `PTCP_ACC_ACC) begin
						den_r <= `PTCP_DEN_FIRST;
					end else if (acc == `PTCP_ACC_DEC) begin
						den_r <= (den_m4 > {16'h0000, `PTCP_DEN_FIRST}) ?
							({2'b00, den_m4} - `PTCP_DEN_FIRST) : `PTCP_DEN_MIN;
					end else begin
						den_r <= `PTCP_DEN_MIN;
					end
					// direction pin; a pure delay leaves it alone
					if (dir == `PTCP_DIR_FWD) begin
						step_output_b <= 1'b1;
					end else if (dir == `PTCP_DIR_REV) begin
						step_output_b <= 1'b0;
					end
					timer_r <= next_width_slot_r;
					if (remaining_step_counter_r == 20'h00000) begin
						state_r <= ST_CHECK;
					end else begin
						state_r <= ST_STEP;
					end
				end
				ST_STEP: begin
					// step pulse high for the first half of the width
					step_output_a <= moving && (timer_r > half_width);
					timer_r <= timer_r - 28'h0000001;
					if (timer_r == 28'h0000001) begin
						remaining_step_counter_r <= remaining_step_counter_r - 20'h00001;
						div_start_r <= (acc == `PTCP_ACC_ACC) || (acc == `PTCP_ACC_DEC);
						state_r <= ST_CALC;
					end
				end
				ST_CALC: begin
					step_output_a <= 1'b0;
					if (acc == `PTCP_ACC_ACC && div_done) begin
						// shrink width, clamped at the minimum
						next_width_slot_r <= (big_delta || w_minus[28] ||
							w_minus[27:0] < `PTCP_WIDTH_MIN) ?
							`PTCP_WIDTH_MIN : w_minus[27:0];
						den_r <= den_r + `PTCP_DEN_STEP;
					end else if (acc == `PTCP_ACC_DEC && div_done) begin
						// widen toward the stop; saturate on overflow
						next_width_slot_r <= (big_delta || w_plus[28]) ?
							28'hFFFFFFF : w_plus[27:0];
						den_r <= (den_r > `PTCP_DEN_STEP + `PTCP_DEN_MIN) ?
							(den_r - `PTCP_DEN_STEP) : `PTCP_DEN_MIN;
					end
					if (div_done || !((acc == `PTCP_ACC_ACC) ||
						(acc == `PTCP_ACC_DEC))) begin
						if (remaining_step_counter_r == 20'h00000) begin
							state_r <= ST_CHECK;
						end else begin
							state_r <= ST_STEP;
						end
					end
				end
				default: state_r <= ST_RESET;
			endcase
			// timer reload for the next step uses the updated width
			if (state_r == ST_CALC) begin
				timer_r <= next_width_slot_r;
			end
			if (state_r == ST_CALC && div_done && acc == `PTCP_ACC_ACC) begin
				timer_r <= (big_delta || w_minus[28] ||
					w_minus[27:0] < `PTCP_WIDTH_MIN) ? `PTCP_WIDTH_MIN : w_minus[27:0];
			end
			if (state_r == ST_CALC && div_done && acc == `PTCP_ACC_DEC) begin
				timer_r <= (big_delta || w_plus[28]) ? 28'hFFFFFFF : w_plus[27:0];
			end
			// writing the reset code forces the block back, outputs low
			if (wr_state && wr_data == `PTCP_CODE_RESET) begin
				state_r <= ST_RESET;
			end
		end
	end
endmodule

/* File: ptcp_profiler_asserts.sv */
// checker for the profiler top-level ports: bus answers and step outputs
// assumes it is bound to ptcp_profiler and sees one aclk domain
`timescale 1ns/100ps
`include "ptcp_consts.vh"
module ptcp_profiler_asserts (
	input wire aclk,
	input wire aresetn,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire step_output_a,
	input wire step_output_b,
	input wire command_accept
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// outputs come out of reset low, whatever ran before
	AST_RESET_LOW: assert property ($rose(aresetn) |-> !step_output_a && !step_output_b && !command_accept)
		else $error("step outputs not low after reset");
	AST_ACCEPT_PULSE: assert property (command_accept |=> !command_accept)
		else $error("accept pulse longer than one cycle");
	// acceptance only between steps, never inside a step pulse
	AST_ACCEPT_GAP: assert property (command_accept |-> !step_output_a)
		else $error("command accepted during a step pulse");
	// widths are at least 64 cycles, so the high half lasts well over 8
	AST_STEP_HIGH: assert property ($rose(step_output_a) |-> step_output_a[*8])
		else $error("step pulse too short");
	// direction may only move right after a command is taken
	AST_DIR_HOLD: assert property ($changed(step_output_b) |-> command_accept
		|| $past(command_accept) || $past(command_accept, 2) || $past(command_accept, 3))
		else $error("direction level changed outside acceptance");
	AST_AR_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_AR_READY: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while answer pending");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped or changed before taken");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped or changed before taken");
	AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == `PTCP_RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("refused read returned data");
endmodule
bind ptcp_profiler ptcp_profiler_asserts u_ptcp_profiler_asserts (.*);

/* File: ptcp_profiler_bench.sv */
// self-checking bench: register map, speed profiles, back-to-back commands
// assumes ptcp_profiler, the host model and the bound checker
`timescale 1ns/100ps
`include "ptcp_consts.vh"
module ptcp_profiler_bench;
	logic aclk;
	logic aresetn;
	wire [4:0] s_axi_awaddr, s_axi_araddr;
	wire [31:0] s_axi_wdata, s_axi_rdata;
	wire [3:0] s_axi_wstrb;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	wire step_output_a, step_output_b, command_accept, hung;
	integer n_fail = 0, comparisons = 0, n_edge = 0, n_acc = 0, n_seen = 0, e0, j;
	logic [34:0] q_r[$];
	logic [1:0] q_b[$];
	logic [31:0] x = 32'h26, got;
	logic prev_a = 1'b0;

	ptcp_profiler u_ptcp_profiler (.*);
	ptcp_host_model u_ptcp_host_model (.*);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	function automatic [31:0] xs(input [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	task chk(input string what, input [34:0] exp, input [34:0] seen);
		comparisons++;
		if (exp !== seen) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task print_verdict;
		$display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task give_up(input string what);
		n_fail++;
		$display("unexpected %s: expected done, seen timeout", what);
		print_verdict;
	endtask

	always @(posedge hung) give_up("bus answer");

	// answers are matched in order against the notes left by the driver
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready && q_r.size() > 0) begin
			if (q_r[0][34]) chk("read", q_r[0][33:0], {s_axi_rresp, s_axi_rdata});
			void'(q_r.pop_front());
		end
		if (s_axi_bvalid && s_axi_bready && q_b.size() > 0) chk("bresp", q_b.pop_front(), s_axi_bresp);
		prev_a <= step_output_a;
		if (step_output_a === 1'b1 && prev_a === 1'b0) n_edge++;
		// accept pulses counted here; a one-cycle pulse may end before a waiter looks
		if (command_accept === 1'b1) n_seen++;
	end

	task rd(input [4:0] a, input [33:0] exp);
		q_r.push_back({1'b1, exp});
		u_ptcp_host_model.rd(a, got);
	endtask

	task wr(input [4:0] a, input [31:0] d, input [1:0] r);
		q_b.push_back(r);
		u_ptcp_host_model.wr(a, d);
	endtask

	// period word strictly before control word, reserved bits zero
	task cmd(input [3:0] dir, input [1:0] acc, input [27:0] per, input [19:0] cnt);
		wr(`PTCP_OFS_PERIOD, {4'h0, per}, 2'h0);
		wr(`PTCP_OFS_CONTROL, {3'h0, 1'b1, dir, acc, 2'h0, cnt}, 2'h0);
	endtask

	task wait_accept;
		for (j = 0; j < 5000 && n_seen <= n_acc; j++) @(posedge aclk);
		if (j >= 5000) give_up("accept");
		n_acc++;
	endtask

	// polling reads leave no note, so the monitor ignores them
	task wait_idle;
		for (j = 0; j < 3000; j++) begin
			u_ptcp_host_model.rd(`PTCP_OFS_STATE, got);
			if (got === `PTCP_CODE_IDLE) break;
		end
		if (j >= 3000) give_up("idle");
	endtask

	task prof(input [3:0] dir, input [1:0] acc, input [27:0] per, input [19:0] cnt,
		input [31:0] w2, input b_exp);
		e0 = n_edge;
		cmd(dir, acc, per, cnt);
		wait_accept;
		rd(`PTCP_OFS_CONTROL, 34'h0);
		chk("first step", dir != `PTCP_DIR_DLY, step_output_a);
		rd(`PTCP_OFS_STATE, {2'h0, `PTCP_CODE_ACTIVE});
		rd(`PTCP_OFS_ACCEPTS, {2'h0, n_acc[31:0]});
		if (dir != `PTCP_DIR_DLY) begin
			for (j = 0; j < 9000 && n_edge < e0 + 2; j++) @(posedge aclk);
			if (n_edge < e0 + 2) give_up("second step");
			rd(`PTCP_OFS_WIDTH, {2'h0, w2});
		end
		wait_idle;
		chk("direction", b_exp, step_output_b);
		chk("step edges", e0 + (dir != `PTCP_DIR_DLY ? cnt : 0), n_edge);
		$display("test profile %h done", acc);
	endtask

	initial begin
		aresetn = 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`PTCP_OFS_STATE, {2'h0, `PTCP_CODE_RESET});
		rd(5'h18, {`PTCP_RESP_SLVERR, 32'h0});
		wr(`PTCP_OFS_COUNT, 32'h5, `PTCP_RESP_SLVERR);
		wr(`PTCP_OFS_STATE, `PTCP_CODE_IDLE, `PTCP_RESP_OKAY);
		rd(`PTCP_OFS_STATE, {2'h0, `PTCP_CODE_IDLE});
		$display("test reset and map done");
		x = xs(x);
		prof(`PTCP_DIR_FWD, `PTCP_ACC_CST, 28'h80 + x[7:0], 20'h2, 32'h80 + x[7:0], 1'b1);
		prof(`PTCP_DIR_REV, `PTCP_ACC_ACC, 28'h3E8, 20'h2, 32'h258, 1'b0);
		prof(`PTCP_DIR_FWD, `PTCP_ACC_DEC, 28'h3E8, 20'h3, 32'h506, 1'b1);
		prof(`PTCP_DIR_DLY, `PTCP_ACC_CST, 28'h64, 20'h2, 32'h64, 1'b1);
		// second command queued while the first still steps, slow answers
		u_ptcp_host_model.slow = 3;
		x = xs(x);
		e0 = n_edge;
		cmd(`PTCP_DIR_FWD, `PTCP_ACC_CST, 28'h100 + x[7:0], 20'h2);
		wait_accept;
		rd(`PTCP_OFS_CONTROL, 34'h0);
		cmd(`PTCP_DIR_REV, `PTCP_ACC_CST, 28'h40, 20'h1);
		rd(`PTCP_OFS_CONTROL, {2'h0, 8'h1F, 4'h0, 20'h1});
		wait_accept;
		chk("steps before accept", e0 + 2, n_edge);
		wait_idle;
		chk("direction", 1'b0, step_output_b);
		chk("step edges", e0 + 3, n_edge);
		$display("test back to back done");
		print_verdict;
	end
endmodule
